// File: design/omc_mode_ctrl.sv
// operating mode control: reset mode select, debug suspend, wait and stop handling
//
// Behaviour
// - highest priority enabled function owns shared pin
// - pin high at release enters run mode
// - run start fetches vector at fffe:ffff
// - pin held low at release enters debug
// - background command enters debug suspend
// - enter-debug instruction enters debug suspend
// - either breakpoint source enters debug suspend
// - debug suspend stops user instruction fetch
// - non-intrusive commands accepted in run, debug
// - active commands only while debug suspended
// - active set: cpu registers, trace, go
// - wait instruction gates cpu clock off
// - wait keeps system clocks and full regulation
// - wait entry clears interrupt mask bit
// - interrupt leaves wait, starts stacking sequence
// - wait honours only background and status access
// - status access in wait reports error only
// - background in wait wakes into debug
// - stop halts clocks; retention depends on depth
// - sixteen debug clocks per serial bit
// - stop needs stop enable bit set
module omc_mode_ctrl
  import omc_pkg::*;
#(
  parameter int BIT_CLKS_P = BIT_CLKS
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        debug_mode_select_pin_level,
  output logic             debug_mode_select_pin_drive,
  output logic             debug_mode_select_pin_oe,
  input  wire logic        gpio_en,
  input  wire logic        gpio_drive,
  input  wire logic        gpio_oe,
  output logic             gpio_grant,
  input  wire logic        sdc_drive,
  input  wire logic        sdc_oe,
  output logic             serial_en,
  output logic             bit_start,
  output logic             bit_end,
  output logic             bit_busy,
  input  wire logic        cmd_valid,
  input  wire omc_cmd_t    cmd_kind,
  output logic             cmd_exec,
  output logic             cmd_stat_err,
  output logic             cmd_reject,
  input  wire logic        sdc_breakpoint,
  input  wire logic        emu_breakpoint,
  input  wire logic        instr_enter_debug,
  input  wire logic        instr_wait,
  input  wire logic        instr_stop,
  input  wire logic        instr_done,
  input  wire logic        stop_enable_bit,
  input  wire logic        stop_deep_sel,
  input  wire logic        sdc_enable,
  input  wire logic        irq_req,
  output omc_state_t       mode_state,
  output logic             reset_vector_fetch,
  output logic [15:0]      reset_vector_addr,
  output logic             cpu_fetch_en,
  output logic             cpu_clk_en,
  output logic             bus_clk_en,
  output logic             sys_clk_on,
  output logic             reg_full,
  output logic             ram_retain,
  output logic             reg_retain,
  output logic             imask_clear,
  output logic             irq_stack_start,
  output logic             illegal_stop
);

  localparam int CW = $clog2(BIT_CLKS_P + 1);

  omc_state_t  state_r;
  omc_state_t  state_nxt;
  logic        pin_s1_r;
  logic        pin_s2_r;
  logic        pin_s3_r;
  logic        serial_en_r;
  logic        stop_deep_r;
  logic [CW-1:0] bit_cnt_r;
  logic        bit_busy_r;
  logic        bit_start_r;
  logic        bit_end_r;
  logic        pin_fall;
  logic        cmd_bg;
  logic        cmd_go;
  logic        cmd_trace;
  logic        exec_nxt;
  logic        err_nxt;
  logic        rej_nxt;
  logic        exec_r;
  logic        err_r;
  logic        rej_r;
  logic        vec_nxt;
  logic        imask_nxt;
  logic        stack_nxt;
  logic        illegal_nxt;
  logic        vec_r;
  logic        imask_r;
  logic        stack_r;
  logic        illegal_r;
  logic        debug_trig;
  logic [PIN_FUNCS-1:0] pin_grant;

  // pin synchroniser; not reset so it keeps tracking the strap during reset
  always_ff @(posedge clk) begin
    pin_s1_r <= debug_mode_select_pin_level;
    pin_s2_r <= pin_s1_r;
  end

  // edge history for the bit timer, fed only from the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s3_r <= PIN_EDGE_RST;
    end else begin
      pin_s3_r <= pin_s2_r;
    end
  end

  // serial use of the pin starts once the strap has been taken and never ends until reset
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_en_r <= SERIAL_EN_RST;
    end else if (state_r == ST_RESET) begin
      serial_en_r <= 1'b1;
    end
  end

  // shared pin: serial debug outranks the port function; nothing drives while strapping
  omc_pin_arb #(
    .N (PIN_FUNCS)
  ) u_pin_arb (
    .func_en    ({serial_en_r, gpio_en & serial_en_r}),
    .func_drive ({sdc_drive, gpio_drive}),
    .func_oe    ({sdc_oe, gpio_oe}),
    .grant      (pin_grant),
    .pin_drive  (debug_mode_select_pin_drive),
    .pin_oe     (debug_mode_select_pin_oe)
  );

  // bit timer: a falling edge starts one bit time, further edges inside it are ignored
  assign pin_fall = serial_en_r & pin_s3_r & ~pin_s2_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      bit_busy_r  <= 1'b0;
      bit_cnt_r   <= '0;
      bit_start_r <= 1'b0;
      bit_end_r   <= 1'b0;
    end else begin
      bit_start_r <= 1'b0;
      bit_end_r   <= 1'b0;
      if (!bit_busy_r) begin
        if (pin_fall) begin
          bit_busy_r  <= 1'b1;
          bit_cnt_r   <= CW'(1);
          bit_start_r <= 1'b1;
        end
      end else if (bit_cnt_r == CW'(BIT_CLKS_P)) begin
        bit_busy_r <= 1'b0;
        bit_end_r  <= 1'b1;
        bit_cnt_r  <= '0;
      end else begin
        bit_cnt_r <= bit_cnt_r + 1'b1;
      end
    end
  end

  // command gate per mode; stop only listens while debug clocks are kept alive
  always_comb begin
    exec_nxt  = 1'b0;
    err_nxt   = 1'b0;
    rej_nxt   = 1'b0;
    cmd_bg    = 1'b0;
    cmd_go    = 1'b0;
    cmd_trace = 1'b0;
    if (cmd_valid) begin
      unique case (state_r)
        ST_RUN, ST_STEP: begin
          if (omc_is_nonintrusive(cmd_kind)) begin
            exec_nxt = 1'b1;
            cmd_bg   = (cmd_kind == CMD_BACKGROUND);
          end else begin
            rej_nxt = 1'b1;
          end
        end
        ST_DEBUG: begin
          exec_nxt  = 1'b1;
          cmd_go    = (cmd_kind == CMD_GO);
          cmd_trace = (cmd_kind == CMD_TRACE);
        end
        ST_WAIT, ST_STOP: begin
          if ((state_r == ST_STOP) && !sdc_enable) begin
            rej_nxt = 1'b1;
          end else if (cmd_kind == CMD_BACKGROUND) begin
            exec_nxt = 1'b1;
            cmd_bg   = 1'b1;
          end else if (cmd_kind == CMD_MEM_STAT) begin
            err_nxt = 1'b1;
          end else begin
            rej_nxt = 1'b1;
          end
        end
        ST_RESET: begin
          rej_nxt = 1'b1;
        end
        default: begin
          rej_nxt = 1'b1;
        end
      endcase
    end
  end

  // any debug entry source; checked before wait or stop so a breakpoint is never lost
  assign debug_trig = cmd_bg | instr_enter_debug | sdc_breakpoint | emu_breakpoint;

  // mode sequencing
  always_comb begin
    state_nxt   = state_r;
    vec_nxt     = 1'b0;
    imask_nxt   = 1'b0;
    stack_nxt   = 1'b0;
    illegal_nxt = 1'b0;
    unique case (state_r)
      ST_RESET: begin
        vec_nxt   = 1'b1;
        state_nxt = pin_s2_r ? ST_RUN : ST_DEBUG;
      end
      ST_RUN: begin
        if (debug_trig) begin
          state_nxt = ST_DEBUG;
        end else if (instr_wait) begin
          state_nxt = ST_WAIT;
          imask_nxt = 1'b1;
        end else if (instr_stop) begin
          if (stop_enable_bit) begin
            state_nxt = ST_STOP;
          end else begin
            illegal_nxt = 1'b1;
          end
        end
      end
      ST_STEP: begin
        if (debug_trig || instr_done) begin
          state_nxt = ST_DEBUG;
        end
      end
      ST_DEBUG: begin
        if (cmd_go) begin
          state_nxt = ST_RUN;
        end else if (cmd_trace) begin
          state_nxt = ST_STEP;
        end
      end
      ST_WAIT: begin
        if (cmd_bg) begin
          state_nxt = ST_DEBUG;
        end else if (irq_req) begin
          state_nxt = ST_RUN;
          stack_nxt = 1'b1;
        end
      end
      ST_STOP: begin
        // the deep stop has no interrupt exit here: it leaves only through reset or a background command
        if (cmd_bg) begin
          state_nxt = ST_DEBUG;
        end else if (irq_req && !stop_deep_r) begin
          state_nxt = ST_RUN;
          stack_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // stop depth is frozen at entry so a later change of the select cannot alter retention
  always_ff @(posedge clk) begin
    if (rst) begin
      stop_deep_r <= STOP_DEEP_RST;
    end else if ((state_r == ST_RUN) && (state_nxt == ST_STOP)) begin
      stop_deep_r <= stop_deep_sel;
    end
  end

  // registered event pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      exec_r    <= 1'b0;
      err_r     <= 1'b0;
      rej_r     <= 1'b0;
      vec_r     <= 1'b0;
      imask_r   <= 1'b0;
      stack_r   <= 1'b0;
      illegal_r <= 1'b0;
    end else begin
      exec_r    <= exec_nxt;
      err_r     <= err_nxt;
      rej_r     <= rej_nxt;
      vec_r     <= vec_nxt;
      imask_r   <= imask_nxt;
      stack_r   <= stack_nxt;
      illegal_r <= illegal_nxt;
    end
  end

  // clock and power controls decoded from the mode register
  assign cpu_fetch_en = (state_r == ST_RUN) || (state_r == ST_STEP);
  assign cpu_clk_en   = (state_r != ST_WAIT) && (state_r != ST_STOP);
  assign bus_clk_en   = (state_r != ST_STOP);
  assign sys_clk_on   = (state_r != ST_STOP);
  assign reg_full     = (state_r != ST_STOP) || sdc_enable;
  assign ram_retain   = 1'b1;
  assign reg_retain   = !((state_r == ST_STOP) && stop_deep_r);

  assign mode_state         = state_r;
  assign reset_vector_fetch = vec_r;
  assign reset_vector_addr  = RESET_VEC_HI;
  assign imask_clear        = imask_r;
  assign irq_stack_start    = stack_r;
  assign illegal_stop       = illegal_r;
  assign cmd_exec           = exec_r;
  assign cmd_stat_err       = err_r;
  assign cmd_reject         = rej_r;
  assign serial_en          = serial_en_r;
  assign gpio_grant         = pin_grant[PIN_FUNC_GPIO];
  assign bit_start          = bit_start_r;
  assign bit_end            = bit_end_r;
  assign bit_busy           = bit_busy_r;

  // checks
  AST_PIN_PRIO: assert property (@(posedge clk) disable iff (rst)
    serial_en_r |-> (debug_mode_select_pin_oe == sdc_oe) && !pin_grant[PIN_FUNC_GPIO])
    else $error("serial debug lost the shared pin");

  AST_STRAP_RUN: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_RESET) && pin_s2_r |=> (state_r == ST_RUN) && reset_vector_fetch)
    else $error("high strap did not start run mode");

  AST_VECTOR: assert property (@(posedge clk) disable iff (rst)
    $fell(serial_en_r) or (reset_vector_fetch |-> $past(state_r) == ST_RESET && reset_vector_addr == 16'hfffe))
    else $error("vector fetch outside reset exit");

  AST_STRAP_DEBUG: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_RESET) && !pin_s2_r |=> (state_r == ST_DEBUG) ##1 !cpu_fetch_en)
    else $error("low strap did not start debug suspend");

  AST_BG_RUN: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_RUN) && cmd_valid && (cmd_kind == CMD_BACKGROUND) |=> (state_r == ST_DEBUG) && cmd_exec)
    else $error("background command ignored in run");

  AST_TRIG: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_RUN) && (instr_enter_debug || sdc_breakpoint || emu_breakpoint) |=> state_r == ST_DEBUG)
    else $error("debug trigger did not suspend the cpu");

  AST_NO_FETCH: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_DEBUG) |-> !cpu_fetch_en)
    else $error("fetch enabled while suspended");

  AST_NONINT: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && omc_is_nonintrusive(cmd_kind) && ((state_r == ST_RUN) || (state_r == ST_DEBUG))
    |=> cmd_exec && !cmd_reject)
    else $error("non-intrusive command not executed");

  AST_ACTIVE_REJ: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && omc_is_active(cmd_kind) && (state_r == ST_RUN) |=> cmd_reject && !cmd_exec && state_r != ST_STEP)
    else $error("active command ran with user code running");

  AST_GO: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_DEBUG) && cmd_valid && (cmd_kind == CMD_GO) |=> (state_r == ST_RUN) && cpu_fetch_en)
    else $error("go did not resume the user program");

  AST_WAIT_IN: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_RUN) && instr_wait && !debug_trig
    |=> imask_clear && !cpu_clk_en && sys_clk_on && reg_full)
    else $error("wait entry wrong");

  AST_WAIT_IRQ: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_WAIT) && irq_req && !cmd_bg |=> (state_r == ST_RUN) && irq_stack_start)
    else $error("interrupt did not leave wait");

  AST_WAIT_REJ: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_WAIT) && cmd_valid && (cmd_kind != CMD_BACKGROUND) && (cmd_kind != CMD_MEM_STAT)
    |=> cmd_reject && !cmd_exec)
    else $error("wait accepted a forbidden command");

  AST_WAIT_STAT: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_WAIT) && cmd_valid && (cmd_kind == CMD_MEM_STAT) |=> cmd_stat_err && !cmd_exec)
    else $error("status access in wait not reported as error");

  AST_WAIT_BG: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_WAIT) && cmd_valid && (cmd_kind == CMD_BACKGROUND) |=> state_r == ST_DEBUG)
    else $error("background did not wake wait into debug");

  AST_STOP: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_STOP) |-> !bus_clk_en && !cpu_clk_en && ram_retain && (reg_retain == !stop_deep_r))
    else $error("stop clocks or retention wrong");

  // checker-only count of cycles since a bit time began; saturates so a stuck timer is still caught
  logic [CW-1:0] ast_bit_cnt_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      ast_bit_cnt_r <= '0;
    end else if (bit_start_r) begin
      ast_bit_cnt_r <= CW'(1);
    end else if (bit_busy_r && (ast_bit_cnt_r != '1)) begin
      ast_bit_cnt_r <= ast_bit_cnt_r + 1'b1;
    end
  end

  AST_BIT: assert property (@(posedge clk) disable iff (rst)
    $rose(bit_busy_r) |-> ##16 bit_end_r)
    else $error("bit time not sixteen clocks");

  AST_BIT_LEN: assert property (@(posedge clk) disable iff (rst)
    bit_end_r |-> (ast_bit_cnt_r == CW'(BIT_CLKS_P)) && !bit_busy_r)
    else $error("bit time ended early or late");

  AST_STOP_GATE: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_RUN) && instr_stop && !stop_enable_bit && !debug_trig && !instr_wait
    |=> (state_r == ST_RUN) && illegal_stop)
    else $error("stop entered without stop enable");

  AST_SERIAL: assert property (@(posedge clk) disable iff (rst)
    serial_en_r |=> serial_en_r && (state_r != ST_RESET))
    else $error("serial use of the pin dropped");

endmodule : omc_mode_ctrl

// File: design/omc_pkg.sv
// package of constants, types and decode functions for the operating mode control block
package omc_pkg;

  // serial debug bit time in debug clocks (debug clock equals clk here)
  localparam int          BIT_CLKS         = 16;

  // reset vector word location, high byte then low byte
  localparam logic [15:0] RESET_VEC_HI     = 16'hfffe;
  localparam logic [15:0] RESET_VEC_LO     = 16'hffff;

  // functions sharing the mode select pin, higher index wins the pin
  localparam int          PIN_FUNCS        = 2;
  localparam int          PIN_FUNC_GPIO    = 0;
  localparam int          PIN_FUNC_SERIAL  = 1;

  // reset values of control flags
  localparam logic        SERIAL_EN_RST    = 1'b0;
  localparam logic        STOP_DEEP_RST    = 1'b0;
  localparam logic        PIN_EDGE_RST     = 1'b1;

  // operating modes, gray along reset -> run -> wait and run -> debug -> step
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_RUN   = 3'h1,
    ST_WAIT  = 3'h3,
    ST_DEBUG = 3'h5,
    ST_STEP  = 3'h4,
    ST_STOP  = 3'h7
  } omc_state_t;

  // decoded serial debug command classes
  typedef enum logic [2:0] {
    CMD_MEM        = 3'h0,
    CMD_MEM_STAT   = 3'h1,
    CMD_SDC_REG    = 3'h2,
    CMD_BACKGROUND = 3'h3,
    CMD_CPU_RD     = 3'h4,
    CMD_CPU_WR     = 3'h5,
    CMD_TRACE      = 3'h6,
    CMD_GO         = 3'h7
  } omc_cmd_t;

  // commands allowed while user code runs
  function automatic logic omc_is_nonintrusive(input omc_cmd_t kind);
    return (kind == CMD_MEM) || (kind == CMD_MEM_STAT) ||
           (kind == CMD_SDC_REG) || (kind == CMD_BACKGROUND);
  endfunction : omc_is_nonintrusive

  // commands that need the cpu suspended
  function automatic logic omc_is_active(input omc_cmd_t kind);
    return !omc_is_nonintrusive(kind);
  endfunction : omc_is_active

endpackage : omc_pkg

// File: design/omc_pin_arb.sv
// priority selector for functions sharing one pin
module omc_pin_arb
  import omc_pkg::*;
#(
  parameter int N = PIN_FUNCS
) (
  input  wire logic [N-1:0] func_en,
  input  wire logic [N-1:0] func_drive,
  input  wire logic [N-1:0] func_oe,
  output logic      [N-1:0] grant,
  output logic              pin_drive,
  output logic              pin_oe
);

  // ascending scan so the highest enabled index is the last to write
  always_comb begin
    grant     = '0;
    pin_drive = 1'b0;
    pin_oe    = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (func_en[i]) begin
        grant     = '0;
        grant[i]  = 1'b1;
        pin_drive = func_drive[i];
        pin_oe    = func_oe[i];
      end
    end
  end

endmodule : omc_pin_arb

// File: bench/omc_debug_host.sv
// behavioural debug host on the single-wire mode select and debug pin
module omc_debug_host (
  input  wire logic clk,
  input  wire logic strap_low,
  input  wire logic bit_req,
  output logic      pull_low
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [4:0] bit_cnt_r;

  initial bit_cnt_r = 5'h00;

  // a new bit is only started once the full bit time of the last one ran out
  always @(posedge clk) begin
    if (bit_cnt_r != 5'h00) begin
      bit_cnt_r <= bit_cnt_r - 5'h01;
    end else if (bit_req) begin
      bit_cnt_r <= 5'h10;
    end
  end

  // strap low holds the pin across reset release; a bit opens with a short low
  assign pull_low = strap_low || (bit_cnt_r > 5'h0c);
endmodule : omc_debug_host

// File: bench/operating_mode_control_tb.sv
// self-checking bench for the operating mode control block
module operating_mode_control_tb
  import omc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] E_CMD = 8'h01;
  localparam logic [7:0] E_WAIT = 8'h02;
  localparam logic [7:0] E_IRQ = 8'h04;
  localparam logic [7:0] E_DONE = 8'h08;
  localparam logic [7:0] E_STOP = 8'h20;
  localparam logic [7:0] E_SBP = 8'h40;

  logic        clk, rst, strap, bit_req, pull_low, pin_level, pin_drive, pin_oe;
  logic        gpio_en, gpio_drive, gpio_oe, gpio_grant, sdc_drive, sdc_oe;
  logic        serial_en, bit_start, bit_end, bit_busy, cmd_valid, cmd_exec, cmd_stat_err, cmd_reject;
  logic        sdc_breakpoint, emu_breakpoint, instr_enter_debug, instr_wait, instr_stop, instr_done;
  logic        stop_enable_bit, stop_deep_sel, sdc_enable, irq_req, reset_vector_fetch, cpu_fetch_en;
  logic        cpu_clk_en, bus_clk_en, sys_clk_on, reg_full, ram_retain, reg_retain;
  logic        imask_clear, irq_stack_start, illegal_stop;
  logic [15:0] reset_vector_addr;
  logic [7:0]  ev_q;
  logic [2:0]  cfg_q, cfg;
  logic [4:0]  pinf_q, pinf;
  logic [18:0] obs;
  logic [31:0] r;
  omc_cmd_t    cmd_kind;
  omc_state_t  mode_state, m;
  int          failures, n_tests, n;

  // event, level and pin-function bundles driven as one
  assign {emu_breakpoint, sdc_breakpoint, instr_stop, instr_enter_debug, instr_done, irq_req, instr_wait,
          cmd_valid} = ev_q;
  assign {sdc_enable, stop_deep_sel, stop_enable_bit} = cfg_q;
  assign {gpio_en, gpio_drive, gpio_oe, sdc_drive, sdc_oe} = pinf_q;
  // pseudo open-drain wire with pull-up: low if either party pulls it down
  assign pin_level = !(pull_low || (pin_oe && !pin_drive));
  assign obs = {gpio_grant, pin_drive, pin_oe, mode_state, cmd_exec, cmd_stat_err, cmd_reject, imask_clear,
                irq_stack_start, illegal_stop, cpu_fetch_en, cpu_clk_en, bus_clk_en, sys_clk_on, reg_full,
                reg_retain, ram_retain};

  omc_debug_host host_u (.clk(clk), .strap_low(strap), .bit_req(bit_req), .pull_low(pull_low));

  omc_mode_ctrl #(.BIT_CLKS_P(16)) dut_u (
    .clk(clk), .rst(rst), .debug_mode_select_pin_level(pin_level), .debug_mode_select_pin_drive(pin_drive),
    .debug_mode_select_pin_oe(pin_oe), .gpio_en(gpio_en), .gpio_drive(gpio_drive), .gpio_oe(gpio_oe),
    .gpio_grant(gpio_grant), .sdc_drive(sdc_drive), .sdc_oe(sdc_oe), .serial_en(serial_en),
    .bit_start(bit_start), .bit_end(bit_end), .bit_busy(bit_busy), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_exec(cmd_exec), .cmd_stat_err(cmd_stat_err), .cmd_reject(cmd_reject),
    .sdc_breakpoint(sdc_breakpoint), .emu_breakpoint(emu_breakpoint), .instr_enter_debug(instr_enter_debug),
    .instr_wait(instr_wait), .instr_stop(instr_stop), .instr_done(instr_done),
    .stop_enable_bit(stop_enable_bit), .stop_deep_sel(stop_deep_sel), .sdc_enable(sdc_enable),
    .irq_req(irq_req), .mode_state(mode_state), .reset_vector_fetch(reset_vector_fetch),
    .reset_vector_addr(reset_vector_addr), .cpu_fetch_en(cpu_fetch_en), .cpu_clk_en(cpu_clk_en),
    .bus_clk_en(bus_clk_en), .sys_clk_on(sys_clk_on), .reg_full(reg_full), .ram_retain(ram_retain),
    .reg_retain(reg_retain), .imask_clear(imask_clear), .irq_stack_start(irq_stack_start),
    .illegal_stop(illegal_stop)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // next mode: debug triggers outrank wait, wait outranks stop
  function automatic omc_state_t nxt_mode(input omc_state_t md, input logic [7:0] ev, input omc_cmd_t k);
    logic bg;
    logic trig;
    bg = ev[0] && (k == CMD_BACKGROUND);
    trig = bg || ev[4] || ev[6] || ev[7];
    case (md)
      ST_RUN: return trig ? ST_DEBUG : ev[1] ? ST_WAIT : (ev[5] && cfg[0]) ? ST_STOP : ST_RUN;
      ST_STEP: return (trig || ev[3]) ? ST_DEBUG : ST_STEP;
      ST_DEBUG: return (ev[0] && k == CMD_TRACE) ? ST_STEP : (ev[0] && k == CMD_GO) ? ST_RUN : ST_DEBUG;
      ST_WAIT: return bg ? ST_DEBUG : ev[2] ? ST_RUN : ST_WAIT;
      ST_STOP: return (bg && cfg[2]) ? ST_DEBUG : (ev[2] && !cfg[1]) ? ST_RUN : ST_STOP;
      default: return md;
    endcase
  endfunction : nxt_mode

  // expected port picture one cycle after an event; answer is {exec, stat_err, reject}
  function automatic logic [18:0] exp_vec(input omc_state_t md, input omc_state_t nm, input logic [7:0] ev,
                                          input omc_cmd_t k);
    logic [2:0] ans;
    ans = 3'h0;
    if (ev[0]) begin
      if (md == ST_DEBUG) ans = 3'h4;
      else if (md == ST_RUN || md == ST_STEP) ans = (k > CMD_BACKGROUND) ? 3'h1 : 3'h4;
      else if (md == ST_WAIT || cfg[2]) ans = (k == CMD_BACKGROUND) ? 3'h4 : (k == CMD_MEM_STAT) ? 3'h2 : 3'h1;
      else ans = 3'h1;
    end
    return {1'b0, pinf[1], pinf[0], nm, ans, md == ST_RUN && nm == ST_WAIT,
            (md == ST_WAIT || md == ST_STOP) && nm == ST_RUN, md == ST_RUN && ev == E_STOP && !cfg[0],
            nm == ST_RUN || nm == ST_STEP, nm != ST_WAIT && nm != ST_STOP, nm != ST_STOP, nm != ST_STOP,
            !(nm == ST_STOP && !cfg[2]), !(nm == ST_STOP && cfg[1]), 1'b1};
  endfunction : exp_vec

  task automatic chk(input string nm, input logic [18:0] e, input logic [18:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic report_and_stop;
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // one event for one cycle, then the whole port picture is compared
  task automatic step(input logic [7:0] ev, input omc_cmd_t k);
    omc_state_t nm;
    @(posedge clk);
    ev_q <= ev;
    cmd_kind <= k;
    cfg_q <= cfg;
    pinf_q <= pinf;
    nm = nxt_mode(m, ev, k);
    @(posedge clk);
    ev_q <= 8'h00;
    #1;
    chk("status", exp_vec(m, nm, ev, k), obs);
    m = nm;
  endtask : step

  // strap is held over the last reset edges and let go once the mode is taken
  task automatic do_reset(input logic low);
    @(posedge clk);
    rst <= 1'b1;
    strap <= low;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    n = 0;
    while (reset_vector_fetch !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    m = low ? ST_DEBUG : ST_RUN;
    chk("vector fetch", 19'(reset_vector_fetch), 19'h1);
    chk("reset exit", {m, RESET_VEC_HI}, {mode_state, reset_vector_addr});
    @(posedge clk);
    strap <= 1'b0;
    #1;
    chk("serial enable", 19'(serial_en), 19'h1);
  endtask : do_reset

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // watchdog: the whole sequence needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    strap = 1'b0;
    bit_req = 1'b0;
    ev_q = 8'h00;
    cmd_kind = CMD_MEM;
    cfg = 3'h4;
    cfg_q = 3'h4;
    pinf = 5'h1f;
    pinf_q = 5'h00;
    failures = 0;
    n_tests = 0;
    m = ST_RESET;
    do_reset(1'b0);
    for (int i = 0; i < 8; i++) begin
      step(E_CMD, omc_cmd_t'(i));
      if (i == 6) step(E_DONE, CMD_MEM);
    end
    for (int i = 7; i >= 0; i--) step(E_CMD, omc_cmd_t'(i));
    step(E_CMD, CMD_GO);
    for (int i = 4; i < 8; i++) begin
      step(8'h01 << i, CMD_MEM);
      step(E_CMD, CMD_GO);
    end
    step(E_WAIT | E_STOP | E_SBP, CMD_MEM);
    step(E_CMD, CMD_GO);
    step(E_WAIT, CMD_MEM);
    for (int i = 0; i < 8; i++) if (i != 3) step(E_CMD, omc_cmd_t'(i));
    step(E_CMD, CMD_BACKGROUND);
    step(E_CMD, CMD_GO);
    step(E_WAIT, CMD_MEM);
    step(E_IRQ, CMD_MEM);
    cfg = 3'h1;
    step(E_STOP, CMD_MEM);
    step(E_IRQ, CMD_MEM);
    cfg = 3'h3;
    step(E_STOP, CMD_MEM);
    step(E_IRQ, CMD_MEM);
    do_reset(1'b1);
    step(E_CMD, CMD_CPU_RD);
    step(E_CMD, CMD_GO);
    // random traffic; a single step always ends on its next instruction
    r = 32'h0001743a;
    repeat (300) begin
      r = lfsr(r);
      cfg = {r[13], 1'b0, r[12]};
      pinf = r[20:16];
      if (m == ST_STEP) step(E_DONE, CMD_MEM);
      else if (r[6:4] == 3'h0) step(E_WAIT << r[10:8], omc_cmd_t'(r[2:0]));
      else step(E_CMD, omc_cmd_t'(r[2:0]));
    end
    // serial bit timing with the device off the pin
    pinf = 5'h00;
    step(8'h00, CMD_MEM);
    repeat (40) @(posedge clk);
    bit_req <= 1'b1;
    @(posedge clk);
    bit_req <= 1'b0;
    n = 0;
    while (bit_start !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("bit start", 19'({bit_start, bit_busy}), 19'h3);
    n = 0;
    while (bit_end !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("bit length", 19'({bit_busy, 5'(n)}), 19'h10);
    report_and_stop();
  end
endmodule : operating_mode_control_tb
